// ### hw/hbd_pkg.sv
// package: command codes, register fields and reset values for the host buffer dma block
package hbd_pkg;
	localparam logic [7:0]  CMD_CFG_RD    = 8'h21; // dma config read code
	localparam logic [7:0]  CMD_CFG_WR    = 8'ha1; // dma config write code
	localparam logic [7:0]  CMD_CNT_RD    = 8'h22; // byte count read code
	localparam logic [7:0]  CMD_CNT_WR    = 8'ha2; // byte count write code
	localparam logic [7:0]  CMD_IRQ_RD    = 8'h24; // irq status read code
	localparam logic [7:0]  CMD_IRQ_WR    = 8'ha4; // irq status write code
	localparam int          CFG_DIR       = 0;     // direction bit
	localparam int          CFG_LIST      = 1;     // list select bit
	localparam int          CFG_USE_CNT   = 2;     // counter select bit
	localparam int          CFG_GO        = 4;     // enable bit
	localparam int          CFG_BURST_LO  = 5;     // burst field low bit
	localparam logic [15:0] CFG_MASK      = 16'h0077; // writable config bits
	localparam logic [15:0] IRQ_MASK      = 16'h0077; // implemented status bits
	localparam int          IRQ_ISO       = 0;     // frame iso list flag
	localparam int          IRQ_ASYNC     = 1;     // async list ready flag
	localparam int          IRQ_DONE      = 2;     // transfer done flag
	localparam int          IRQ_OPER      = 4;     // operational event flag
	localparam int          IRQ_SUSP      = 5;     // host suspended flag
	localparam int          IRQ_CLK       = 6;     // clock ready flag
	localparam logic [15:0] CFG_RESET     = 16'h0000; // config reset value
	localparam logic [15:0] CNT_RESET     = 16'h0000; // byte count reset value
	localparam logic [15:0] IRQ_RESET     = 16'h0000; // status reset value
	localparam logic [15:0] CLEAR_ALL     = 16'h00ff; // clear-all write value
	localparam logic [15:0] MAX_ASYNC_CNT = 16'h1000; // async list count limit
	localparam logic [15:0] MAX_ISO_CNT   = 16'h0800; // iso list count limit
	localparam logic [1:0]  BURST_SINGLE  = 2'h0;  // single-cycle burst
	localparam logic [1:0]  BURST_FOUR    = 2'h1;  // four-cycle burst
	localparam logic [1:0]  BURST_EIGHT   = 2'h2;  // eight-cycle burst
	typedef enum logic [1:0] {
		XF_IDLE  = 2'b00, // no dma
		XF_REQ   = 2'b01, // request raised
		XF_BURST = 2'b11  // burst in progress
	} hbd_xfer_type;
	// beats per burst for a burst code
	function automatic logic [3:0] burst_beats(input logic [1:0] sel);
		case (sel)
			BURST_FOUR:  burst_beats = 4'h4;
			BURST_EIGHT: burst_beats = 4'h8;
			default:     burst_beats = 4'h1;
		endcase
	endfunction
endpackage

// ### hw/hbd_bus_if.sv
// interface: shared microprocessor command bus and dma handshake
`timescale 1ns/1ps
interface hbd_bus_if;
	logic        cmd_valid; // one-cycle command strobe
	logic [7:0]  cmd_code;  // command code
	logic [15:0] wdata;     // write data with command
	logic [15:0] rdata;     // read data from device
	logic        rvalid;    // read data valid pulse
	logic        dreq;      // dma request from device
	logic        dack;      // one-cycle beat acknowledge
	logic        eot_ext;   // external end-of-transfer pulse
	logic        irq;       // host interrupt
	modport dev (input cmd_valid, cmd_code, wdata, dack, eot_ext, output rdata, rvalid, dreq, irq);
	modport host (output cmd_valid, cmd_code, wdata, dack, eot_ext, input rdata, rvalid, dreq, irq);
endinterface

// ### hw/hbd_beat_counter.sv
// module: byte counter that flags when the programmed count is reached
`timescale 1ns/1ps
module hbd_beat_counter #(
	parameter int W = 16 // counter width
) (
	input  wire logic         i_clk,    // clock
	input  wire logic         i_arst_n, // async reset
	input  wire logic         i_load,   // load target, clear count
	input  wire logic [W-1:0] i_target, // target count
	input  wire logic         i_step,   // one byte moved
	output logic              o_hit     // count reached target
);
	logic [W-1:0] cnt_r;   // bytes moved
	logic [W-1:0] cnt_nxt; // next count
	logic [W-1:0] tgt_r;   // target
	logic [W-1:0] tgt_nxt; // next target
	// next-count logic
	always_comb begin
		cnt_nxt = cnt_r;
		tgt_nxt = tgt_r;
		if (i_load) begin
			cnt_nxt = '0;
			tgt_nxt = i_target;
		end else if (i_step) begin
			cnt_nxt = W'(cnt_r + 1'b1);
		end
	end
	// registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= '0;
			tgt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			tgt_r <= tgt_nxt;
		end
	end
	// flag as the last byte is stepped
	assign o_hit = i_step && !i_load && (W'(cnt_r + 1'b1) == tgt_r);
endmodule

// ### hw/hbd_device.sv
// module: host controller dma configuration, byte counter and interrupt status
`timescale 1ns/1ps
module hbd_device
	import hbd_pkg::*;
(
	input  wire logic  I_CLK,             // 200 mhz clock
	input  wire logic  I_ARST_N,          // async reset, active low
	hbd_bus_if.dev     bus,               // microprocessor bus
	input  wire logic  I_IRQ_MASTER_EN,   // master interrupt enable
	input  wire logic [15:0] I_IRQ_ENABLE, // interrupt enable register
	input  wire logic  I_ISO_EVENT,       // frame iso list event pulse
	input  wire logic  I_ASYNC_READY,     // async list data ready pulse
	input  wire logic  I_OPER_EVENT,      // operational event pulse
	input  wire logic  I_SUSP_EVENT,      // host suspended pulse
	input  wire logic  I_CLK_READY,       // clock ready pulse
	output logic       O_LIST_SEL,        // 0 iso, 1 async buffer
	output logic       O_DIR_WRITE,       // 1 writes buffer ram
	output logic       O_BEAT,            // one byte moved pulse
	output logic       O_XFER_DONE        // end-of-transfer pulse to buffer state
);
	import hbd_pkg::*;
	logic [15:0]  cfg_r;    // dma config
	logic [15:0]  cfg_nxt;  // next dma config
	logic [15:0]  cnt_r;    // transfer byte count
	logic [15:0]  cnt_nxt;  // next byte count
	logic [15:0]  irq_r;    // irq status
	logic [15:0]  irq_nxt;  // next irq status
	logic [15:0]  rd_r;     // read data
	logic [15:0]  rd_nxt;   // next read data
	logic         rv_r;     // read valid
	logic         rv_nxt;   // next read valid
	logic         done_r;   // done pulse
	logic         done_nxt; // next done pulse
	logic [3:0]   beat_r;   // beats left in burst
	logic [3:0]   beat_nxt; // next beats left
	hbd_xfer_type st_r;     // dma state
	hbd_xfer_type st_nxt;   // next dma state
	logic         wr_cfg;   // config write this cycle
	logic         wr_cnt;   // count write this cycle
	logic         wr_irq;   // status write this cycle
	logic         go_set;   // enable bit rising by write
	logic         hit;      // counter reached target
	logic         end_of_transfer;      // end of transfer this cycle
	logic         load;     // reload byte counter
	logic [15:0]  set_bits; // event bits this cycle

	// command decode
	always_comb begin
		// defaults: no write this cycle
		wr_cfg = 1'b0;
		wr_cnt = 1'b0;
		wr_irq = 1'b0;
		// write codes, checked one after another
		if (bus.cmd_valid && bus.cmd_code == CMD_CFG_WR) begin
			wr_cfg = 1'b1;
		end else if (bus.cmd_valid && bus.cmd_code == CMD_CNT_WR) begin
			wr_cnt = 1'b1;
		end else if (bus.cmd_valid && bus.cmd_code == CMD_IRQ_WR) begin
			wr_irq = 1'b1;
		end
	end

	// go rising from a config write; reload counter then if the same write selects the counter
	assign go_set = wr_cfg && bus.wdata[CFG_GO] && !cfg_r[CFG_GO];
	assign load   = go_set && bus.wdata[CFG_USE_CNT];
	// counts moved bytes against the programmed count
	hbd_beat_counter #(.W(16)) u_cnt (
		.i_clk    (I_CLK),
		.i_arst_n (I_ARST_N),
		.i_load   (load),
		.i_target (cnt_r),
		.i_step   (O_BEAT),
		.o_hit    (hit)
	);

	// internal end when counter used, else external end
	assign end_of_transfer = (cfg_r[CFG_USE_CNT] ? hit : bus.eot_ext) && st_r != XF_IDLE;
	// a beat only counts while a transfer runs
	assign O_BEAT = bus.dack && st_r != XF_IDLE;

	// events set status bits
	always_comb begin
		// reserved positions stay zero
		set_bits = 16'h0000;
		set_bits[IRQ_ISO]   = I_ISO_EVENT;
		set_bits[IRQ_ASYNC] = I_ASYNC_READY;
		set_bits[IRQ_DONE]  = end_of_transfer;
		set_bits[IRQ_OPER]  = I_OPER_EVENT;
		set_bits[IRQ_SUSP]  = I_SUSP_EVENT;
		set_bits[IRQ_CLK]   = I_CLK_READY;
	end

	// register and dma next-state logic
	always_comb begin
		// hold every register but the read valid and done pulses unless a write, a read or an event moves it
		cfg_nxt  = cfg_r;
		cnt_nxt  = cnt_r;
		irq_nxt  = irq_r;
		st_nxt   = st_r;
		beat_nxt = beat_r;
		done_nxt = end_of_transfer;
		rv_nxt   = 1'b0;
		rd_nxt   = rd_r;
		// config write; reserved bits forced to zero
		if (wr_cfg) begin
			cfg_nxt = bus.wdata & CFG_MASK;
		end
		// byte count write, taken as given
		if (wr_cnt) begin
			cnt_nxt = bus.wdata;
		end
		// writing ones clears status bits
		if (wr_irq) begin
			irq_nxt = irq_r & ~bus.wdata;
		end
		// events land after the clear so a same-cycle event survives
		irq_nxt = (irq_nxt | set_bits) & IRQ_MASK; // set wins over clear
		// read answer one cycle after the command
		if (bus.cmd_valid && bus.cmd_code == CMD_CFG_RD) begin
			// config read
			rd_nxt = cfg_r;
			rv_nxt = 1'b1;
		end else if (bus.cmd_valid && bus.cmd_code == CMD_CNT_RD) begin
			// byte count read
			rd_nxt = cnt_r;
			rv_nxt = 1'b1;
		end else if (bus.cmd_valid && bus.cmd_code == CMD_IRQ_RD) begin
			// status read leaves bits as they are
			rd_nxt = irq_r;
			rv_nxt = 1'b1;
		end
		// dma request state machine
		case (st_r)
			XF_IDLE: begin
				// counter mode needs non-zero count
				if (go_set && (!bus.wdata[CFG_USE_CNT] || cnt_r != 16'h0000)) begin
					st_nxt = XF_REQ;
				end
			end
			XF_REQ: begin
				if (bus.dack) begin
					// first beat; the burst code sets the beats left
					beat_nxt = 4'(burst_beats(cfg_r[CFG_BURST_LO+:2]) - 1'b1);
					st_nxt   = (beat_nxt == 4'h0) ? XF_REQ : XF_BURST;
				end
			end
			XF_BURST: begin
				if (bus.dack) begin
					beat_nxt = 4'(beat_r - 1'b1);
					// last beat of a burst waits for the next one
					if (beat_r == 4'h1) begin
						st_nxt = XF_REQ;
					end
				end
			end
			// unused code falls back to idle
			default: st_nxt = XF_IDLE;
		endcase
		// end of transfer drops the request and the enable bit
		if (end_of_transfer) begin
			st_nxt = XF_IDLE;
			cfg_nxt[CFG_GO] = 1'b0;
		end
		// enable written to zero terminates at once
		if (wr_cfg && !bus.wdata[CFG_GO]) begin
			st_nxt = XF_IDLE;
		end
	end

	// registers
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			// all registers zero, dma idle
			cfg_r  <= CFG_RESET;
			cnt_r  <= CNT_RESET;
			irq_r  <= IRQ_RESET;
			st_r   <= XF_IDLE;
			beat_r <= 4'h0;
			done_r <= 1'b0;
			rv_r   <= 1'b0;
			rd_r   <= 16'h0000;
		end else begin
			// take the next values
			cfg_r  <= cfg_nxt;
			cnt_r  <= cnt_nxt;
			irq_r  <= irq_nxt;
			st_r   <= st_nxt;
			beat_r <= beat_nxt;
			done_r <= done_nxt;
			rv_r   <= rv_nxt;
			rd_r   <= rd_nxt;
		end
	end

	// outputs
	// read port straight from flops
	assign bus.rdata  = rd_r;
	assign bus.rvalid = rv_r;
	// request stands while not idle
	assign bus.dreq   = st_r != XF_IDLE;
	// status gated by its enable and the master enable
	assign bus.irq    = I_IRQ_MASTER_EN && |(irq_r & I_IRQ_ENABLE & IRQ_MASK);
	// config bits and done pulse to the buffer side
	assign O_LIST_SEL  = cfg_r[CFG_LIST];
	assign O_DIR_WRITE = cfg_r[CFG_DIR];
	assign O_XFER_DONE = done_r;
endmodule

// ### hw/hbd_host.sv
// module: microprocessor side issuing commands and acknowledging dma beats
`timescale 1ns/1ps
module hbd_host
	import hbd_pkg::*;
(
	input  wire logic        I_CLK,      // 200 mhz clock
	input  wire logic        I_ARST_N,   // async reset, active low
	hbd_bus_if.host          bus,        // microprocessor bus
	input  wire logic        I_CMD_GO,   // user command strobe
	input  wire logic [7:0]  I_CMD_CODE, // user command code
	input  wire logic [15:0] I_CMD_DATA, // user write data
	input  wire logic        I_ACK_EN,   // allow beat acknowledge
	input  wire logic        I_EOT,      // user external end pulse
	output logic [15:0]      O_RDATA,    // captured read data
	output logic             O_RVALID,   // read data pulse
	output logic             O_IRQ,      // interrupt seen
	output logic             O_BUSY      // dma request pending
);
	import hbd_pkg::*;
	logic [15:0] rd_r, rd_nxt; // captured data
	logic        rv_r, rv_nxt; // valid pulse
	logic        cv_r, cv_nxt; // command strobe
	logic [7:0]  cc_r, cc_nxt; // command code
	logic [15:0] wd_r, wd_nxt; // write data
	logic        ak_r, ak_nxt; // beat acknowledge
	logic        eo_r, eo_nxt; // external end
	logic        ls_r, ls_nxt; // list select of last config write
	logic [15:0] lim;          // byte count limit for that list
	// next values
	always_comb begin
		cv_nxt = I_CMD_GO;
		cc_nxt = I_CMD_GO ? I_CMD_CODE : cc_r;
		ls_nxt = (I_CMD_GO && I_CMD_CODE == CMD_CFG_WR) ? I_CMD_DATA[CFG_LIST] : ls_r;
		lim    = ls_r ? MAX_ASYNC_CNT : MAX_ISO_CNT;
		wd_nxt = I_CMD_GO ? I_CMD_DATA : wd_r;
		// counter limit per list on count writes
		if (I_CMD_GO && I_CMD_CODE == CMD_CNT_WR && I_CMD_DATA > lim) begin
			wd_nxt = lim;
		end
		ak_nxt = I_ACK_EN && bus.dreq && !ak_r;
		eo_nxt = I_EOT;
		rv_nxt = bus.rvalid;
		rd_nxt = bus.rvalid ? bus.rdata : rd_r;
	end
	// registers
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cv_r <= 1'b0;
			cc_r <= 8'h00;
			wd_r <= 16'h0000;
			ak_r <= 1'b0;
			eo_r <= 1'b0;
			ls_r <= 1'b0;
			rv_r <= 1'b0;
			rd_r <= 16'h0000;
		end else begin
			cv_r <= cv_nxt;
			cc_r <= cc_nxt;
			wd_r <= wd_nxt;
			ak_r <= ak_nxt;
			eo_r <= eo_nxt;
			ls_r <= ls_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
		end
	end
	assign bus.cmd_valid = cv_r;
	assign bus.cmd_code  = cc_r;
	assign bus.wdata     = wd_r;
	assign bus.dack      = ak_r;
	assign bus.eot_ext   = eo_r;
	assign O_RDATA  = rd_r;
	assign O_RVALID = rv_r;
	assign O_IRQ    = bus.irq;
	assign O_BUSY   = bus.dreq;
endmodule

// ### tb/hbd_bus_asserts.sv
// checker: command answers and dma request timing on the bus
`timescale 1ns/1ps
module hbd_bus_asserts
	import hbd_pkg::*;
(
	input  wire logic        I_CLK,     // clock
	input  wire logic        I_ARST_N,  // async reset
	input  wire logic        cmd_valid, // command strobe
	input  wire logic [7:0]  cmd_code,  // command code
	input  wire logic [15:0] wdata,     // write data
	input  wire logic [15:0] rdata,     // read data
	input  wire logic        rvalid,    // read answer
	input  wire logic        dreq,      // dma request
	input  wire logic        dack,      // beat acknowledge
	input  wire logic        eot_ext    // external end pulse
);
	logic [15:0] cnt_r;   // last byte count written
	logic [15:0] beats_r; // beats since last config write
	logic        use_r;   // counter select of last config write
	logic        rd_c;    // a read command is on the bus
	assign rd_c = cmd_valid && (cmd_code inside {CMD_CFG_RD, CMD_CNT_RD, CMD_IRQ_RD});
	// shadow of what software wrote, plus a beat tally
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cnt_r <= 16'h0000;
			beats_r <= 16'h0000;
			use_r <= 1'b0;
		end else if (cmd_valid && cmd_code == CMD_CNT_WR) begin
			cnt_r <= wdata;
		end else if (cmd_valid && cmd_code == CMD_CFG_WR) begin
			use_r <= wdata[CFG_USE_CNT];
			beats_r <= 16'h0000;
		end else if (dack && dreq) begin
			beats_r <= beats_r + 16'h0001;
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	// config write carrying the enable bit
	sequence s_go_wr;
		cmd_valid && cmd_code == CMD_CFG_WR && wdata[CFG_GO];
	endsequence
	a_read_answer: assert property (rd_c |=> rvalid)
		else $error("read command got no answer");
	a_answer_cause: assert property (rvalid |-> $past(rd_c))
		else $error("answer without a read command");
	a_count_readback: assert property (cmd_valid && cmd_code == CMD_CNT_RD |=> rdata == cnt_r)
		else $error("byte count read back wrong");
	a_go_plain: assert property (s_go_wr ##0 !wdata[CFG_USE_CNT] |-> ##[1:2] dreq)
		else $error("no request after enable");
	a_stop_drops: assert property (cmd_valid && cmd_code == CMD_CFG_WR && !wdata[CFG_GO] |-> ##[1:2] !dreq)
		else $error("request kept after terminate");
	a_zero_idle: assert property (s_go_wr ##0 (wdata[CFG_USE_CNT] && cnt_r == 16'h0000) |=> !dreq [*4])
		else $error("request raised with zero count");
	a_count_end: assert property (use_r && cnt_r != 16'h0000 && beats_r == cnt_r |-> !dreq)
		else $error("request kept after count reached");
	a_eot_ends: assert property (eot_ext && dreq && !use_r |-> ##[1:3] !dreq)
		else $error("request kept after external end");
endmodule

// ### tb/test_hbd_device.sv
// testbench: both bus ends joined, scenarios driven from the host user side
`timescale 1ns/1ps
module test_hbd_device;
	import hbd_pkg::*;
	logic        clk = 0, rst_n = 0, go = 0, ack_en = 0, end_of_transfer = 0, mst = 0;
	logic [7:0]  code = 8'h00;     // user command code
	logic [15:0] data = 16'h0000;  // user write data
	logic [15:0] en = 16'h0000;    // interrupt enables
	logic [4:0]  ev = 5'h00;       // status event pulses
	logic [15:0] rdata;            // captured read data
	logic        rvld, irq, busy, lsel, dirw, beat, done;
	int          miscompares = 0, checks = 0;
	hbd_bus_if bus ();
	hbd_device u_hbd_device (.I_CLK(clk), .I_ARST_N(rst_n), .bus(bus.dev), .I_IRQ_MASTER_EN(mst),
		.I_IRQ_ENABLE(en), .I_ISO_EVENT(ev[0]), .I_ASYNC_READY(ev[1]), .I_OPER_EVENT(ev[2]),
		.I_SUSP_EVENT(ev[3]), .I_CLK_READY(ev[4]), .O_LIST_SEL(lsel), .O_DIR_WRITE(dirw),
		.O_BEAT(beat), .O_XFER_DONE(done));
	hbd_host u_hbd_host (.I_CLK(clk), .I_ARST_N(rst_n), .bus(bus.host), .I_CMD_GO(go), .I_CMD_CODE(code),
		.I_CMD_DATA(data), .I_ACK_EN(ack_en), .I_EOT(end_of_transfer), .O_RDATA(rdata), .O_RVALID(rvld),
		.O_IRQ(irq), .O_BUSY(busy));
	hbd_bus_asserts u_hbd_bus_asserts (.I_CLK(clk), .I_ARST_N(rst_n), .cmd_valid(bus.cmd_valid),
		.cmd_code(bus.cmd_code), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
		.dreq(bus.dreq), .dack(bus.dack), .eot_ext(bus.eot_ext));
	// 200 mhz clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one command, then one idle cycle so the strobe is never reassigned in a step
	task automatic cmd(input logic [7:0] c, input logic [15:0] d);
		code = c;
		data = d;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		@(negedge clk);
	endtask
	// read and compare; a missing answer counts too
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		int n;
		cmd(c, 16'h0000);
		for (n = 0; n < 8 && rvld !== 1'b1; n++) @(negedge clk);
		chk(16'(rvld), 16'h0001);
		chk(rdata, e);
	endtask
	// wait for end pulse, counting beats
	task automatic wait_done(output int b);
		int n;
		b = 0;
		for (n = 0; n < 100 && done !== 1'b1; n++) begin
			@(negedge clk);
			if (beat === 1'b1) b++;
		end
		chk(16'(done), 16'h0001);
	endtask
	task automatic t_regs();
		int i, n;
		rd(CMD_CFG_RD, 16'h0000);
		rd(CMD_CNT_RD, 16'h0000);
		rd(CMD_IRQ_RD, 16'h0000);
		cmd(CMD_CNT_WR, MAX_ASYNC_CNT);
		rd(CMD_CNT_RD, 16'h0800);
		cmd(CMD_CFG_WR, 16'hff8b);
		rd(CMD_CFG_RD, 16'h0003);
		cmd(CMD_CNT_WR, 16'hffff);
		rd(CMD_CNT_RD, 16'h1000);
		for (i = 0; i < 4; i++) begin
			cmd(CMD_CFG_WR, 16'((i % 3) << 5 | i));
			rd(CMD_CFG_RD, 16'((i % 3) << 5 | i));
			chk(16'({lsel, dirw}), 16'({i[1], i[0]}));
		end
		cmd(8'h30, 16'h0000);
		for (n = 0; n < 6 && rvld !== 1'b1; n++) @(negedge clk);
		chk(16'(rvld), 16'h0000);
	endtask
	task automatic t_counted();
		int b;
		ack_en = 1'b1;
		cmd(CMD_CNT_WR, 16'h0003);
		cmd(CMD_CFG_WR, 16'h0014);
		wait_done(b);
		chk(16'(b), 16'h0003);
		rd(CMD_CFG_RD, 16'h0004);
		rd(CMD_IRQ_RD, 16'h0004);
		rd(CMD_IRQ_RD, 16'h0004);
		cmd(CMD_IRQ_WR, 16'h0004);
		rd(CMD_IRQ_RD, 16'h0000);
	endtask
	task automatic t_external();
		int b;
		cmd(CMD_CFG_WR, 16'h0010);
		repeat (6) @(negedge clk);
		chk(16'(busy), 16'h0001);
		end_of_transfer = 1'b1;
		@(negedge clk);
		end_of_transfer = 1'b0;
		wait_done(b);
		rd(CMD_CFG_RD, 16'h0000);
		rd(CMD_IRQ_RD, 16'h0004);
		cmd(CMD_IRQ_WR, 16'h0004);
	endtask
	task automatic t_stop();
		ack_en = 1'b0;
		cmd(CMD_CNT_WR, 16'h0000);
		cmd(CMD_CFG_WR, 16'h0014);
		repeat (4) @(negedge clk);
		chk(16'(busy), 16'h0000);
		cmd(CMD_CNT_WR, 16'h0010);
		cmd(CMD_CFG_WR, 16'h0000);
		cmd(CMD_CFG_WR, 16'h0014);
		chk(16'(busy), 16'h0001);
		cmd(CMD_CFG_WR, 16'h0000);
		@(negedge clk);
		chk(16'(busy), 16'h0000);
	endtask
	task automatic t_irq();
		ev = 5'h1f;
		@(negedge clk);
		ev = 5'h00;
		rd(CMD_IRQ_RD, 16'h0073);
		mst = 1'b1;
		en = 16'h0002;
		@(negedge clk);
		chk(16'(irq), 16'h0001);
		en = 16'h0004;
		@(negedge clk);
		chk(16'(irq), 16'h0000);
		en = 16'h0002;
		mst = 1'b0;
		@(negedge clk);
		chk(16'(irq), 16'h0000);
		cmd(CMD_IRQ_WR, 16'h0002);
		rd(CMD_IRQ_RD, 16'h0071);
		cmd(CMD_IRQ_WR, CLEAR_ALL);
		rd(CMD_IRQ_RD, 16'h0000);
		mst = 1'b1;
		en = 16'hffff;
		@(negedge clk);
		chk(16'(irq), 16'h0000);
	endtask
	// watchdog well past the expected run
	initial begin
		#50000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_regs();
		t_counted();
		t_external();
		t_stop();
		t_irq();
		report_and_stop();
	end
endmodule
